//--- wid_pkg.sv
/*
  Constants and types shared by the wakeup interrupt detection block.
  Assumes a single synchronous clock domain and no register bus.
*/
`default_nettype none
package wid_pkg;
  localparam int unsigned NUM_WAKE     = 8;   // Wake-capable sources.
  localparam int unsigned NUM_PIN_WAKE = 4;   // Low sources that come from pins.
  localparam int unsigned NUM_IRQ      = 32;  // Core controller sources.
  localparam int unsigned PRIO_W       = 2;   // Priority field width.
  localparam int unsigned ID_W         = 5;   // Width of a source number.
  localparam logic [15:0] WAKE_CLR_OFFSET = 16'h0060; // Request-clear register offset.
  localparam logic [1:0]  PRIO_LOWEST  = 2'h3;
  localparam logic [1:0]  PRIO_HIGHEST = 2'h0;

  // Active level select encoding.
  typedef enum logic [1:0] {
    WID_LVL_LOW  = 2'b00,
    WID_LVL_HIGH = 2'b01,
    WID_EDGE_FALL = 2'b10,
    WID_EDGE_RISE = 2'b11
  } wid_sense_t;
endpackage : wid_pkg
`default_nettype wire

//--- wid_wake_if.sv
/*
  Interface that carries the wake requests from the detector to the top.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface wid_wake_if #(parameter int unsigned N = 8);
  logic [N-1:0] req;       // Request level toward the core.
  logic [N-1:0] clr;       // One-cycle clear per source.
  modport det (output req, input clr);
  modport top (input req, output clr);
endinterface : wid_wake_if
`default_nettype wire

//--- wid_wake_det.sv
/*
  Clock-generator style wake detector: edge latch or level pass per source.
  Assumes source inputs are synchronous to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module wid_wake_det
  import wid_pkg::*;
#(
  parameter int unsigned N     = NUM_WAKE,
  parameter int unsigned N_PIN = NUM_PIN_WAKE
) (
  input  wire logic           clk_i,
  input  wire logic           rstn_i,
  input  wire logic           en_i,
  input  wire logic [N-1:0]   src_i,
  input  wire logic [N-1:0]   src_en_i,
  input  wire logic [2*N-1:0] sense_i,
  wid_wake_if.det             wk
);
  logic [N-1:0] prev_q;
  logic [N-1:0] held_q;

  // Previous input sample for edge detection.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= '0;
    end else if (en_i) begin
      prev_q <= src_i;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_src
    wid_sense_t s;
    logic       is_edge;
    logic       hit;
    // Peripheral sources only know edges; level codes fall back to edges.
    assign s = (i >= N_PIN) ? wid_sense_t'({1'b1, sense_i[2*i]})
                            : wid_sense_t'(sense_i[2*i+1:2*i]);
    assign is_edge = s[1];
    always_comb begin
      case (s)
        WID_LVL_LOW:   hit = !src_i[i];
        WID_LVL_HIGH:  hit = src_i[i];
        WID_EDGE_FALL: hit = prev_q[i] && !src_i[i];
        WID_EDGE_RISE: hit = !prev_q[i] && src_i[i];
        default:       hit = 1'b0;
      endcase
    end
    // Edge hits are held until cleared; a new edge beats a clear.
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        held_q[i] <= 1'b0;
      end else if (en_i) begin
        if (src_en_i[i] && is_edge && hit) begin
          held_q[i] <= 1'b1;
        end else if (wk.clr[i] || !is_edge || !src_en_i[i]) begin
          held_q[i] <= 1'b0;
        end
      end
    end
    // Level requests are live, never latched; both forms drive high.
    assign wk.req[i] = src_en_i[i] && (is_edge ? held_q[i] : hit);
  end
endmodule : wid_wake_det
`default_nettype wire

//--- wid_top.sv
/*
  Wakeup interrupt detection and routing: wake detector, pin input enables,
  peripheral mask and flags, and a core-side controller with priority arbiter.
  Assumes all inputs synchronous to clk_i; registers are plain ports.
*/
// Functional notes
// - The core treats a high interrupt input as a service request.
// - Peripheral lines wired straight to the core go high for a pending request.
// - Peripheral wake sources support only rising or falling edge detection.
// - Pin wake sources support high level, low level, rising and falling edge.
// - Each wake source has an enable and a level select; disabled sources ignored.
// - A detected wake request goes to the core as a high level.
// - A detected edge request is held after the input returns inactive.
// - Level requests are not held and vanish when the input drops early.
// - An edge wake request stays high until software clears it or its source is disabled.
// - An uncleared held request survives standby exit and is seen again.
// - The request-clear code clears only that source's held request.
// - After a clear, a new active edge makes a new request.
// - A level request persists while active and drops when the source drops.
// - Each source has a two-bit priority, zero the highest.
// - Equal priorities resolve to the lowest source number.
// - With the global mask set, all maskable interrupts are blocked.
// - Higher priority requests still preempt a running lower-priority service.
// - A pin interrupt passes only while its port input enable is set.
// - The mask register passes or blocks each peripheral factor separately.
// - Writing one to a flag bit clears that held peripheral factor.
// - Set-enable, clear-pending and set-pending write ones per source.
// - The request-clear register sits at offset 0x0060.
`timescale 1ns/10ps
`default_nettype none
module wid_top
  import wid_pkg::*;
#(
  parameter int unsigned N_WAKE  = NUM_WAKE,
  parameter int unsigned N_PIN   = NUM_PIN_WAKE,
  parameter int unsigned N_IRQ   = NUM_IRQ,
  parameter int unsigned N_FACT  = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic                en_i,
  // Wake sources: pins in the low indexes, peripherals above.
  input  wire logic [N_WAKE-1:0]   wake_src_i,
  input  wire logic [N_PIN-1:0]    port_input_enable_i,
  input  wire logic [N_WAKE-1:0]   wake_source_enable_i,
  input  wire logic [2*N_WAKE-1:0] wake_active_level_select_i,
  // Request-clear write: offset and source code.
  input  wire logic                wake_request_clear_we_i,
  input  wire logic [15:0]         wake_request_clear_addr_i,
  input  wire logic [7:0]          wake_request_clear_code_i,
  // Peripheral factors through the mask function.
  input  wire logic [N_FACT-1:0]   fact_src_i,
  input  wire logic [N_FACT-1:0]   peripheral_irq_gate_i,
  input  wire logic                peripheral_irq_flags_we_i,
  input  wire logic [N_FACT-1:0]   peripheral_irq_flags_wdata_i,
  output logic [N_FACT-1:0]        peripheral_irq_flags_o,
  // Direct peripheral lines into the core controller.
  input  wire logic [N_IRQ-1:0]    direct_irq_i,
  // Core controller.
  input  wire logic                set_enable_we_i,
  input  wire logic                clr_enable_we_i,
  input  wire logic                set_pending_we_i,
  input  wire logic                clr_pending_we_i,
  input  wire logic [N_IRQ-1:0]    irq_wdata_i,
  input  wire logic [2*N_IRQ-1:0]  irq_prio_i,
  input  wire logic                global_irq_mask_i,
  input  wire logic                svc_done_i,
  output logic [N_IRQ-1:0]         irq_enable_o,
  output logic [N_IRQ-1:0]         irq_pending_o,
  output logic [N_WAKE-1:0]        wake_req_o,
  output logic                     irq_take_o,
  output logic [ID_W-1:0]          irq_id_o,
  output logic                     svc_active_o,
  output logic [PRIO_W-1:0]        svc_prio_o
);
  wid_wake_if #(.N(N_WAKE)) wk ();

  logic [N_WAKE-1:0] gated_en;
  logic [N_FACT-1:0] flags_q;
  logic [N_IRQ-1:0]  line;
  logic [N_IRQ-1:0]  enable_q;
  logic [N_IRQ-1:0]  pend_q;
  logic [N_IRQ-1:0]  line_prev_q;
  logic              svc_q;
  logic [PRIO_W-1:0] svc_prio_q;
  logic [ID_W-1:0]   id_q;
  logic              take_q;
  logic              win_v;
  logic [ID_W-1:0]   win_id;
  logic [PRIO_W-1:0] win_prio;
  logic              win_beaten;
  logic              clr_hit;

  // Pins only take part in detection while their input enable is set.
  // Gating the enable, not the pin, keeps a low-level or falling-edge
  // sense from seeing a blocked pin as active.
  always_comb begin
    gated_en = wake_source_enable_i;
    gated_en[N_PIN-1:0] = wake_source_enable_i[N_PIN-1:0] & port_input_enable_i;
  end

  // Request-clear write decodes the source code into a one-hot clear.
  assign clr_hit = wake_request_clear_we_i
                   && (wake_request_clear_addr_i == WAKE_CLR_OFFSET);
  for (genvar i = 0; i < N_WAKE; i++) begin : g_clr
    assign wk.clr[i] = clr_hit && (wake_request_clear_code_i == 8'(i));
  end

  wid_wake_det #(.N(N_WAKE), .N_PIN(N_PIN)) u_det (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .en_i     (en_i),
    .src_i    (wake_src_i),
    .src_en_i (gated_en),
    .sense_i  (wake_active_level_select_i),
    .wk       (wk)
  );
  // Held requests have no standby clear path, so they persist until written or disabled.
  assign wake_req_o = wk.req;

  // Peripheral factor flags: set by a masked factor, cleared by writing one.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= '0;
    end else if (en_i) begin
      flags_q <= (fact_src_i & peripheral_irq_gate_i)
               | (flags_q & ~(peripheral_irq_flags_we_i ? peripheral_irq_flags_wdata_i
                                                       : '0));
    end
  end
  assign peripheral_irq_flags_o = flags_q;

  // Core lines: direct lines, wake requests in the slots below the top one, and the flag OR in the top slot.
  always_comb begin
    line = direct_irq_i;
    line[N_IRQ-1] = direct_irq_i[N_IRQ-1] | (|flags_q);
    line[N_IRQ-2 -: N_WAKE] = direct_irq_i[N_IRQ-2 -: N_WAKE] | wk.req;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_prev_q <= '0;
    end else if (en_i) begin
      line_prev_q <= line;
    end
  end

  // Enable bits: write one to set or clear.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_q <= '0;
    end else if (en_i) begin
      if (set_enable_we_i) enable_q <= enable_q | irq_wdata_i;
      else if (clr_enable_we_i) enable_q <= enable_q & ~irq_wdata_i;
    end
  end

  // Pending: a rising line sets it and beats clear, a steady high line sets it; taking clears it.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q <= '0;
    end else if (en_i) begin
      for (int i = 0; i < N_IRQ; i++) begin
        if ((line[i] && !line_prev_q[i]) || (set_pending_we_i && irq_wdata_i[i])) begin
          pend_q[i] <= 1'b1;
        end else if ((clr_pending_we_i && irq_wdata_i[i])
                     || (take_q && id_q == ID_W'(i))) begin
          pend_q[i] <= 1'b0;
        end else if (line[i]) begin
          pend_q[i] <= 1'b1;
        end
      end
    end
  end

  // Arbiter: lowest priority value wins, lowest number on ties.
  always_comb begin
    win_v    = 1'b0;
    win_id   = '0;
    win_prio = PRIO_LOWEST;
    for (int i = 0; i < N_IRQ; i++) begin
      if (pend_q[i] && enable_q[i] && !(take_q && id_q == ID_W'(i))) begin
        if (!win_v || irq_prio_i[2*i +: 2] < win_prio) begin
          win_v    = 1'b1;
          win_id   = ID_W'(i);
          win_prio = irq_prio_i[2*i +: 2];
        end
      end
    end
  end

  // Checker aid: flags any eligible source that should have beaten the winner.
  always_comb begin
    win_beaten = 1'b0;
    for (int i = 0; i < N_IRQ; i++) begin
      if (win_v && pend_q[i] && enable_q[i] && !(take_q && id_q == ID_W'(i))
          && (irq_prio_i[PRIO_W*i +: PRIO_W] < win_prio
              || (irq_prio_i[PRIO_W*i +: PRIO_W] == win_prio && ID_W'(i) < win_id))) begin
        win_beaten = 1'b1;
      end
    end
  end

  // Take a request when unmasked and idle or strictly more urgent.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take_q     <= 1'b0;
      id_q       <= '0;
      svc_q      <= 1'b0;
      svc_prio_q <= PRIO_LOWEST;
    end else if (en_i) begin
      take_q <= 1'b0;
      if (win_v && !global_irq_mask_i && !take_q
          && (!svc_q || win_prio < svc_prio_q)) begin
        take_q     <= 1'b1;
        id_q       <= win_id;
        svc_q      <= 1'b1;
        svc_prio_q <= win_prio;
      end else if (svc_done_i) begin
        svc_q      <= 1'b0;
        svc_prio_q <= PRIO_LOWEST;
      end
    end
  end

  assign irq_enable_o  = enable_q;
  assign irq_pending_o = pend_q;
  assign irq_take_o    = take_q;
  assign irq_id_o      = id_q;
  assign svc_active_o  = svc_q;
  assign svc_prio_o    = svc_prio_q;

  property p_mask_blocks;
    @(posedge clk_i) disable iff (!rstn_i)
      (en_i && global_irq_mask_i) |=> !take_q;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("Take while masked.");

  property p_preempt;
    @(posedge clk_i) disable iff (!rstn_i)
      (en_i && take_q && $past(svc_q) && $past(en_i)) |-> svc_prio_q < $past(svc_prio_q);
  endproperty
  a_preempt: assert property (p_preempt) else $error("Preempt not more urgent.");

  property p_pin_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      !port_input_enable_i[0] |-> !wk.req[0];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("Pin passes while disabled.");

  sequence s_flag_clear;
    en_i && peripheral_irq_flags_we_i && peripheral_irq_flags_wdata_i[0];
  endsequence
  property p_flag_clear;
    @(posedge clk_i) disable iff (!rstn_i)
      (s_flag_clear and !(fact_src_i[0] && peripheral_irq_gate_i[0])) |=> !flags_q[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Flag not cleared.");

  property p_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      (en_i && fact_src_i[0] && peripheral_irq_gate_i[0]) |=> flags_q[0];
  endproperty
  a_gate: assert property (p_gate) else $error("Gated factor lost.");

  property p_set_enable;
    @(posedge clk_i) disable iff (!rstn_i)
      (en_i && set_enable_we_i && irq_wdata_i[0]) |=> enable_q[0];
  endproperty
  a_set_enable: assert property (p_set_enable) else $error("Enable not set.");

  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      (en_i && wk.req[N_PIN] && wake_source_enable_i[N_PIN] && !wk.clr[N_PIN])
        ##1 wake_source_enable_i[N_PIN] |-> wk.req[N_PIN];
  endproperty
  a_hold: assert property (p_hold) else $error("Edge request dropped.");

  // A high-level pin request follows its pin and is never held.
  property p_level_live;
    @(posedge clk_i) disable iff (!rstn_i)
      (wake_active_level_select_i[1:0] == WID_LVL_HIGH && !wake_src_i[0]) |-> !wk.req[0];
  endproperty
  a_level_live: assert property (p_level_live) else $error("Level request held.");

  // A selected rising edge on the first peripheral source raises a held request.
  sequence s_rise_seen;
    en_i && wake_source_enable_i[N_PIN] && wake_active_level_select_i[2*N_PIN]
    && !u_det.prev_q[N_PIN] && wake_src_i[N_PIN];
  endsequence
  property p_edge_set;
    @(posedge clk_i) disable iff (!rstn_i)
      s_rise_seen ##1 wake_source_enable_i[N_PIN] |-> wk.req[N_PIN];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("Rising edge not held.");

  // A rising core line marks its source pending on the next edge.
  for (genvar i = 0; i < N_IRQ; i++) begin : g_pend_chk
    property p_line_pends;
      @(posedge clk_i) disable iff (!rstn_i)
        (en_i && line[i] && !line_prev_q[i]) |=> pend_q[i];
    endproperty
    a_line_pends: assert property (p_line_pends) else $error("Rising line not pending.");
  end

  property p_clear;
    @(posedge clk_i) disable iff (!rstn_i)
      (en_i && wk.clr[N_PIN] && (wake_src_i[N_PIN] == u_det.prev_q[N_PIN]))
        |=> !u_det.held_q[N_PIN];
  endproperty
  a_clear: assert property (p_clear) else $error("Clear did not drop request.");

  property p_tie;
    @(posedge clk_i) disable iff (!rstn_i)
      win_v |-> (pend_q[win_id] && enable_q[win_id] && !win_beaten);
  endproperty
  a_tie: assert property (p_tie) else $error("Winner not the most urgent.");
endmodule : wid_top
`default_nettype wire

//--- wid_isr_model.sv
/*
  Service model for the far side: it stands in for the handler that runs
  after each taken request and reports the end of service.
  Assumes one clock shared with the block and an active-low async reset.
*/
`timescale 1ns/10ps
`default_nettype none
module wid_isr_model #(
  parameter int unsigned SVC_CYC = 20
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic take_i,
  output logic      svc_done_o
);
  int unsigned depth_q;
  int unsigned cnt_q;

  // Each take opens a service of fixed length; a preempting take nests on top.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      depth_q    <= 0;
      cnt_q      <= 0;
      svc_done_o <= 1'b0;
    end else begin
      svc_done_o <= 1'b0;
      if (take_i) begin
        depth_q <= depth_q + 1;
        cnt_q   <= SVC_CYC;
      end else if (depth_q != 0) begin
        if (cnt_q == 1) begin
          svc_done_o <= 1'b1;
          depth_q    <= depth_q - 1;
          cnt_q      <= SVC_CYC;
        end else begin
          cnt_q <= cnt_q - 1;
        end
      end
    end
  end
endmodule : wid_isr_model
`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the wakeup interrupt detection block.
  Assumes wid_top with default parameters and the service model beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import wid_pkg::*;
  logic              clk_i  = 1'b0;
  logic              rstn_i = 1'b0;
  logic              en     = 1'b1;
  logic              sact;
  logic [1:0]        sprio;
  logic [7:0]        src    = 8'haa;
  logic [3:0]        pen    = 4'h0;
  logic [7:0]        sen    = 8'h00;
  logic              cwe    = 1'b0;
  logic [15:0]       caddr  = 16'h0000;
  logic [7:0]        ccode  = 8'h00;
  logic [7:0]        fsrc   = 8'h00;
  logic [7:0]        gate   = 8'h00;
  logic              fwe    = 1'b0;
  logic [7:0]        fdat   = 8'h00;
  logic [31:0]       dirq   = 32'h0000_0000;
  logic [2:0]        cwr    = 3'h0;
  logic [31:0]       wdat   = 32'h0000_0000;
  logic [63:0]       prio   = '1;
  logic              gmask  = 1'b1;
  logic              done;
  logic [7:0]        flags;
  logic [7:0]        wreq;
  logic [31:0]       ena;
  logic [31:0]       pend;
  logic              take;
  logic [ID_W-1:0]   id;
  int                mismatches = 0;
  int                cmp_count  = 0;

  // Block under test; sense map: pins high, low, rise, fall; peripherals rise/fall.
  wid_top wid_top_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .en_i(en), .wake_src_i(src),
    .port_input_enable_i(pen), .wake_source_enable_i(sen),
    .wake_active_level_select_i(16'hbbb1), .wake_request_clear_we_i(cwe),
    .wake_request_clear_addr_i(caddr), .wake_request_clear_code_i(ccode),
    .fact_src_i(fsrc), .peripheral_irq_gate_i(gate), .peripheral_irq_flags_we_i(fwe),
    .peripheral_irq_flags_wdata_i(fdat), .peripheral_irq_flags_o(flags),
    .direct_irq_i(dirq), .set_enable_we_i(cwr[2]), .clr_enable_we_i(1'b0),
    .set_pending_we_i(cwr[1]), .clr_pending_we_i(cwr[0]), .irq_wdata_i(wdat),
    .irq_prio_i(prio), .global_irq_mask_i(gmask), .svc_done_i(done),
    .irq_enable_o(ena), .irq_pending_o(pend), .wake_req_o(wreq), .irq_take_o(take),
    .irq_id_o(id), .svc_active_o(sact), .svc_prio_o(sprio)
  );

  // Handler stand-in that ends each service after a fixed time.
  wid_isr_model wid_isr_model_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .take_i(take), .svc_done_o(done)
  );

  always #4 clk_i = ~clk_i;

  task automatic summarize;
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One write to the request-clear register.
  task automatic clr_wake(input logic [15:0] a, input logic [7:0] c);
    cwe = 1'b1;
    caddr = a;
    ccode = c;
    cyc(1);
    cwe = 1'b0;
    cyc(1);
  endtask : clr_wake

  task automatic clr_all;
    for (int i = 0; i < 8; i++) clr_wake(WAKE_CLR_OFFSET, 8'(i));
  endtask : clr_all

  // One pulse on the set-enable, set-pending or clear-pending strobes.
  task automatic core_wr(input logic [2:0] k, input logic [31:0] d);
    cwr = k;
    wdat = d;
    cyc(1);
    cwr = 3'h0;
    cyc(1);
  endtask : core_wr

  task automatic wait_take(input logic [ID_W-1:0] exp_id);
    int k = 0;
    while (take !== 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    check(take, 1'b1);
    check(id, exp_id);
    cyc(1);
  endtask : wait_take

  // Every sense, latching, clearing and the two enables of the wake detector.
  task automatic t_wake;
    sen = 8'hff;
    pen = 4'hf;
    cyc(2);
    check(wreq, 8'h00);
    src = 8'h55;
    cyc(2);
    check(wreq, 8'hff);
    src = 8'haa;
    cyc(2);
    check(wreq, 8'hfc);
    clr_wake(16'h0064, 8'h04);
    check(wreq, 8'hfc);
    clr_wake(WAKE_CLR_OFFSET, 8'h04);
    check(wreq, 8'hec);
    clr_all();
    check(wreq, 8'h00);
    src = 8'h55;
    cyc(2);
    check(wreq, 8'hff);
    src = 8'haa;
    clr_all();
    pen = 4'h0;
    src = 8'h55;
    cyc(2);
    check(wreq, 8'hf0);
    src = 8'haa;
    clr_all();
    sen = 8'h00;
    src = 8'h55;
    cyc(2);
    check(wreq, 8'h00);
    src = 8'haa;
  endtask : t_wake

  // Gated peripheral factors and write-one clearing of the flags.
  task automatic t_flags;
    gate = 8'h0f;
    fsrc = 8'h11;
    en = 1'b0;
    cyc(2);
    check(flags, 8'h00);
    en = 1'b1;
    cyc(2);
    check(flags, 8'h01);
    fsrc = 8'h00;
    cyc(2);
    check(flags, 8'h01);
    fwe = 1'b1;
    fdat = 8'h01;
    cyc(1);
    fwe = 1'b0;
    cyc(1);
    check(flags, 8'h00);
  endtask : t_flags

  // Masking, tie-break by number, and preemption by a more urgent source.
  task automatic t_prio;
    prio[5:4] = 2'b01;
    prio[11:10] = 2'b01;
    prio[19:18] = 2'b00;
    core_wr(3'b001, 32'hffff_ffff);
    core_wr(3'b100, 32'h0000_0224);
    dirq = 32'h0000_0024;
    repeat (6) begin
      cyc(1);
      check(take, 1'b0);
    end
    check(pend & 32'h0000_0224, 32'h0000_0024);
    check(ena, 32'h0000_0224);
    gmask = 1'b0;
    wait_take(5'd2);
    check(sprio, 2'h1);
    dirq = 32'h0000_0020;
    wait_take(5'd5);
    dirq = 32'h0000_0000;
    core_wr(3'b010, 32'h0000_0200);
    wait_take(5'd9);
    check(sact, 1'b1);
    check(sprio, 2'h0);
  endtask : t_prio

  initial begin
    cyc(3);
    rstn_i = 1'b1;
    cyc(1);
    t_wake();
    t_flags();
    t_prio();
    cyc(2);
    summarize();
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    summarize();
  end
endmodule : tb
`default_nettype wire
